/* File: hw/prs_pin_remap_select.sv */
// Operation
// [R1] Remap bit 7 ignores writes, reads zero
// [R2] UART bit moves TX/RX pins
// [R3] Second interrupt input on PD0 or PD5
// [R4] First interrupt input on PF1 or PF2
// [R5] Standard timer 1 pins remapped
// [R6] Periodic timer pins remapped
// [R7] Standard timer 0 pins remapped
// [R8] LCD common lines moved by bit 0
// [R9] Rightmost named output function wins pin
// [R10] Data and direction registers reset ones
// [R11] New output drives data register value
// [R12] Bit set/clear rewrites whole port byte
// [R13] A/D pins reset to analog input
// [R14] Converter stays off until enabled
// [R15] Software removes analog before digital use
// [R16] Analog channel disconnects pull-high resistor
// [R17] Port A falling edge wakes sleep
// [R18] Remap change acts immediately after write
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "prs_consts.svh"

module prs_pin_remap_select #(
    parameter logic [47:0] ANALOG_PINS = 48'h0000_0000_00FF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [47:0] port_pin_in,
    output logic [47:0] port_pin_out,
    output logic [47:0] port_pin_oe,
    output logic [47:0] port_pull_en,
    output logic [47:0] port_analog_sel,
    output logic adc_power_on,
    input wire logic sleep_mode,
    output logic wake_up,
    output logic irq,
    input wire logic uart_tx,
    input wire logic uart_tx_en,
    output logic uart_rx,
    output logic ext_irq0_input,
    output logic ext_irq1_input,
    input wire logic std_timer0_output,
    input wire logic std_timer0_output_en,
    output logic std_timer0_capture_in,
    output logic std_timer0_ext_clock,
    input wire logic std_timer1_output,
    input wire logic std_timer1_output_en,
    output logic std_timer1_capture_in,
    output logic std_timer1_ext_clock,
    input wire logic periodic_timer_output,
    input wire logic periodic_timer_output_en,
    output logic periodic_timer_capture_in,
    output logic periodic_timer_ext_clock,
    input wire logic lcd_common_line3,
    input wire logic lcd_common_line2,
    input wire logic lcd_common_en
);

    localparam prs_pkg::prs_state_type STATE_RST = '{
        remap: `PRS_REMAP_RST,
        adc_on: 1'b0,
        data: {6{`PRS_PORT_RST}},
        dir: {6{`PRS_PORT_RST}},
        pull: {6{`PRS_BYTE_ZERO}},
        ana: ANALOG_PINS,
        wake_en: `PRS_BYTE_ZERO,
        status: `PRS_BYTE_ZERO,
        mask: `PRS_BYTE_ZERO,
        pa_prev: `PRS_PORT_RST,
        prdata: `PRS_WORD_ZERO,
        slverr: 1'b0
    };

    prs_pkg::prs_state_type q;
    prs_pkg::prs_state_type d;
    logic [47:0] data_flat;
    logic [47:0] dir_flat;
    logic [47:0] pull_flat;
    logic [47:0] ana_flat;
    logic [7:0] wake_events;

    function automatic prs_pkg::prs_reg_type prs_decode(input logic [11:0] a);
        prs_decode = prs_pkg::REG_NONE;
        if (a[`PRS_LANE_FIELD] == 2'b00) begin
            if (a[`PRS_PAGE_FIELD] == `PRS_PORT_PAGE) begin
                if (a[`PRS_PORT_FIELD] < `PRS_NUM_PORTS) begin
                    case (a[`PRS_SLOT_FIELD])
                        `PRS_SLOT_DATA: prs_decode = prs_pkg::REG_DATA;
                        `PRS_SLOT_DIR: prs_decode = prs_pkg::REG_DIR;
                        `PRS_SLOT_PULL: prs_decode = prs_pkg::REG_PULL;
                        `PRS_SLOT_ANA: prs_decode = prs_pkg::REG_ANA;
                        `PRS_SLOT_PIN: prs_decode = prs_pkg::REG_PIN;
                        default: prs_decode = prs_pkg::REG_NONE;
                    endcase
                end
            end else begin
                case (a)
                    `PRS_REMAP_ADDR: prs_decode = prs_pkg::REG_REMAP;
                    `PRS_ADC_ADDR: prs_decode = prs_pkg::REG_ADC;
                    `PRS_WAKE_EN_ADDR: prs_decode = prs_pkg::REG_WAKE_EN;
                    `PRS_STATUS_ADDR: prs_decode = prs_pkg::REG_STATUS;
                    `PRS_MASK_ADDR: prs_decode = prs_pkg::REG_MASK;
                    `PRS_BITOP_ADDR: prs_decode = prs_pkg::REG_BITOP;
                    default: prs_decode = prs_pkg::REG_NONE;
                endcase
            end
        end
    endfunction

    assign data_flat = q.data;
    assign dir_flat = q.dir;
    assign pull_flat = q.pull;
    assign ana_flat = q.ana;

    // Falling edges on wake-enabled Port A pins while asleep
    assign wake_events = q.pa_prev & ~port_pin_in[7:0] & q.wake_en & {8{sleep_mode}}; // see [R17]

    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.slverr;
    assign adc_power_on = q.adc_on; // see [R14]
    assign port_analog_sel = ana_flat;
    assign wake_up = |wake_events; // see [R17]
    assign irq = |(q.status & q.mask);

    always_comb begin
        prs_pkg::prs_reg_type rsel;
        logic [2:0] port;
        logic [2:0] bop_port;
        logic [7:0] byte_val;
        rsel = prs_decode(paddr);
        port = paddr[`PRS_PORT_FIELD];
        bop_port = pwdata[`PRS_BOP_PORT];
        byte_val = `PRS_BYTE_ZERO;
        d = q;
        d.pa_prev = port_pin_in[7:0];

        // Setup phase: latch read data so the access phase answers at once
        if (psel && !penable) begin
            d.slverr = (rsel == prs_pkg::REG_NONE);
            case (rsel)
                prs_pkg::REG_REMAP: d.prdata = 32'(q.remap); // see [R1]
                prs_pkg::REG_ADC: d.prdata = 32'(q.adc_on);
                prs_pkg::REG_WAKE_EN: d.prdata = 32'(q.wake_en);
                prs_pkg::REG_STATUS: d.prdata = 32'(q.status);
                prs_pkg::REG_MASK: d.prdata = 32'(q.mask);
                prs_pkg::REG_DATA: d.prdata = 32'(q.data[port]);
                prs_pkg::REG_DIR: d.prdata = 32'(q.dir[port]);
                prs_pkg::REG_PULL: d.prdata = 32'(q.pull[port]);
                prs_pkg::REG_ANA: d.prdata = 32'(q.ana[port]);
                prs_pkg::REG_PIN: d.prdata = 32'(port_pin_in[port*8 +: 8]);
                default: d.prdata = `PRS_WORD_ZERO;
            endcase
        end

        if (psel && penable && !q.slverr) begin
            if (pwrite) begin
                case (rsel)
                    prs_pkg::REG_REMAP: d.remap = pwdata[6:0]; // see [R1] [R18]
                    prs_pkg::REG_ADC: d.adc_on = pwdata[0]; // see [R14]
                    prs_pkg::REG_WAKE_EN: d.wake_en = pwdata[7:0];
                    prs_pkg::REG_MASK: d.mask = pwdata[7:0];
                    prs_pkg::REG_DATA: d.data[port] = pwdata[7:0];
                    prs_pkg::REG_DIR: d.dir[port] = pwdata[7:0];
                    prs_pkg::REG_PULL: d.pull[port] = pwdata[7:0];
                    prs_pkg::REG_ANA: d.ana[port] = pwdata[7:0]; // see [R15]
                    prs_pkg::REG_BITOP: begin
                        if (bop_port < `PRS_NUM_PORTS) begin
                            // Whole byte read, one bit changed, whole byte written
                            if (pwdata[`PRS_BOP_DIR]) begin
                                byte_val = q.dir[bop_port];
                            end else begin
                                byte_val = port_pin_in[bop_port*8 +: 8]; // see [R12]
                            end
                            byte_val[pwdata[`PRS_BOP_BIT]] = pwdata[`PRS_BOP_SET];
                            if (pwdata[`PRS_BOP_DIR]) begin
                                d.dir[bop_port] = byte_val;
                            end else begin
                                d.data[bop_port] = byte_val; // see [R12]
                            end
                        end
                    end
                    default: d.mask = q.mask;
                endcase
            end else if (rsel == prs_pkg::REG_STATUS) begin
                // Clear only what was reported
                d.status = q.status & ~q.prdata[7:0];
            end
        end

        // Set wins over read clear
        d.status = d.status | wake_events; // see [R17]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RST; // see [R10] [R13]
        end else begin
            q <= d;
        end
    end

    // Pin drive: GPIO first, then peripherals in rising priority
    always_comb begin
        logic [5:0] idx;
        idx = '0;
        port_pin_out = data_flat; // see [R11]
        port_pin_oe = ~dir_flat & ~ana_flat; // see [R11] [R13]
        port_pull_en = pull_flat & ~ana_flat; // see [R16]

        idx = q.remap[`PRS_RMP_STM0] ? `PRS_PD3 : `PRS_PC2; // see [R7]
        if (std_timer0_output_en && !ana_flat[idx]) begin
            port_pin_out[idx] = std_timer0_output; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
        idx = q.remap[`PRS_RMP_STM1] ? `PRS_PE3 : `PRS_PB5; // see [R5]
        if (std_timer1_output_en && !ana_flat[idx]) begin
            port_pin_out[idx] = std_timer1_output; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
        idx = q.remap[`PRS_RMP_PTM] ? `PRS_PD1 : `PRS_PE2; // see [R6]
        if (periodic_timer_output_en && !ana_flat[idx]) begin
            port_pin_out[idx] = periodic_timer_output; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
        idx = q.remap[`PRS_RMP_UART] ? `PRS_PE5 : `PRS_PB4; // see [R2]
        if (uart_tx_en && !ana_flat[idx]) begin
            port_pin_out[idx] = uart_tx; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
        idx = q.remap[`PRS_RMP_LCD] ? `PRS_PD2 : `PRS_PC7; // see [R8]
        if (lcd_common_en && !ana_flat[idx]) begin
            port_pin_out[idx] = lcd_common_line3; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
        idx = q.remap[`PRS_RMP_LCD] ? `PRS_PD7 : `PRS_PC6; // see [R8]
        if (lcd_common_en && !ana_flat[idx]) begin
            port_pin_out[idx] = lcd_common_line2; // see [R9]
            port_pin_oe[idx] = 1'b1;
        end
    end

    // Input routing straight from the current remap bits
    assign uart_rx = port_pin_in[q.remap[`PRS_RMP_UART] ? `PRS_PE4 : `PRS_PC3]; // see [R2] [R18]
    assign ext_irq1_input = port_pin_in[q.remap[`PRS_RMP_IRQ1] ? `PRS_PD5 : `PRS_PD0]; // see [R3]
    assign ext_irq0_input = port_pin_in[q.remap[`PRS_RMP_IRQ0] ? `PRS_PF2 : `PRS_PF1]; // see [R4]
    assign std_timer1_capture_in = port_pin_in[q.remap[`PRS_RMP_STM1] ? `PRS_PA7 : `PRS_PB7]; // see [R5]
    assign std_timer1_ext_clock = port_pin_in[q.remap[`PRS_RMP_STM1] ? `PRS_PE5 : `PRS_PE7]; // see [R5]
    assign periodic_timer_capture_in = port_pin_in[q.remap[`PRS_RMP_PTM] ? `PRS_PD4 : `PRS_PB6]; // see [R6]
    assign periodic_timer_ext_clock = port_pin_in[q.remap[`PRS_RMP_PTM] ? `PRS_PD2 : `PRS_PC3]; // see [R6]
    assign std_timer0_capture_in = port_pin_in[q.remap[`PRS_RMP_STM0] ? `PRS_PD6 : `PRS_PA5]; // see [R7]
    assign std_timer0_ext_clock = port_pin_in[q.remap[`PRS_RMP_STM0] ? `PRS_PE4 : `PRS_PA6]; // see [R7]

endmodule // prs_pin_remap_select

/* File: pkg/prs_consts.svh */
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Register map, byte addresses
`define PRS_ADDR_W 12
`define PRS_REMAP_ADDR 12'h000
`define PRS_ADC_ADDR 12'h004
`define PRS_WAKE_EN_ADDR 12'h008
`define PRS_STATUS_ADDR 12'h00C
`define PRS_MASK_ADDR 12'h010
`define PRS_BITOP_ADDR 12'h014
`define PRS_PORT_PAGE 4'h1
`define PRS_PAGE_FIELD 11:8
`define PRS_PORT_FIELD 7:5
`define PRS_SLOT_FIELD 4:2
`define PRS_LANE_FIELD 1:0
`define PRS_SLOT_DATA 3'h0
`define PRS_SLOT_DIR 3'h1
`define PRS_SLOT_PULL 3'h2
`define PRS_SLOT_ANA 3'h3
`define PRS_SLOT_PIN 3'h4
`define PRS_NUM_PORTS 3'h6

// Remap register fields
`define PRS_RMP_LCD 0
`define PRS_RMP_STM0 1
`define PRS_RMP_PTM 2
`define PRS_RMP_STM1 3
`define PRS_RMP_IRQ0 4
`define PRS_RMP_IRQ1 5
`define PRS_RMP_UART 6

// Bit operation register fields
`define PRS_BOP_BIT 2:0
`define PRS_BOP_PORT 6:4
`define PRS_BOP_SET 8
`define PRS_BOP_DIR 9

// Reset values
`define PRS_PORT_RST 8'hFF
`define PRS_REMAP_RST 7'h00
`define PRS_BYTE_ZERO 8'h00
`define PRS_WORD_ZERO 32'h0000_0000

// Pin indices, port * 8 + bit
`define PRS_PA5 6'd5
`define PRS_PA6 6'd6
`define PRS_PA7 6'd7
`define PRS_PB4 6'd12
`define PRS_PB5 6'd13
`define PRS_PB6 6'd14
`define PRS_PB7 6'd15
`define PRS_PC2 6'd18
`define PRS_PC3 6'd19
`define PRS_PC6 6'd22
`define PRS_PC7 6'd23
`define PRS_PD0 6'd24
`define PRS_PD1 6'd25
`define PRS_PD2 6'd26
`define PRS_PD3 6'd27
`define PRS_PD4 6'd28
`define PRS_PD5 6'd29
`define PRS_PD6 6'd30
`define PRS_PD7 6'd31
`define PRS_PE2 6'd34
`define PRS_PE3 6'd35
`define PRS_PE4 6'd36
`define PRS_PE5 6'd37
`define PRS_PE7 6'd39
`define PRS_PF1 6'd41
`define PRS_PF2 6'd42

`endif

/* File: pkg/prs_pkg.sv */
package prs_pkg;

    typedef enum {
        REG_NONE,
        REG_REMAP,
        REG_ADC,
        REG_WAKE_EN,
        REG_STATUS,
        REG_MASK,
        REG_BITOP,
        REG_DATA,
        REG_DIR,
        REG_PULL,
        REG_ANA,
        REG_PIN
    } prs_reg_type;

    typedef struct packed {
        logic [6:0] remap;
        logic adc_on;
        logic [5:0][7:0] data;
        logic [5:0][7:0] dir;
        logic [5:0][7:0] pull;
        logic [5:0][7:0] ana;
        logic [7:0] wake_en;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] pa_prev;
        logic [31:0] prdata;
        logic slverr;
    } prs_state_type;

endpackage

/* File: verif/prs_board.sv */
`timescale 1ns/10ps
module prs_board (
    input wire logic pclk,
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] pull_en,
    input wire logic [47:0] ext_val,
    input wire logic [47:0] ext_drv,
    output logic [47:0] level
);
    logic [47:0] float_q = 48'h5555_5555_5555;

    // Open pins with no pull wander every cycle
    always @(posedge pclk) begin
        float_q <= ~float_q;
    end

    assign level = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) | (~pin_oe & ~ext_drv & (pull_en | float_q));
endmodule // prs_board

/* File: verif/prs_remap_monitor.sv */
`timescale 1ns/10ps
`include "prs_consts.svh"
module prs_remap_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic [47:0] port_pin_in,
    input wire logic [47:0] port_pull_en,
    input wire logic [47:0] port_analog_sel,
    input wire logic sleep_mode,
    input wire logic wake_up,
    input wire logic uart_rx,
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic std_timer1_capture_in,
    input wire logic periodic_timer_ext_clock,
    input wire logic std_timer0_ext_clock
);
    logic [6:0] rm_q;
    wire logic [47:0] p = port_pin_in;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the remap selects
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rm_q <= 7'h00;
        else if (psel && penable && pready && pwrite && paddr == `PRS_REMAP_ADDR) rm_q <= pwdata[6:0];
    end

    sequence remap_read;
        psel && penable && pready && !pwrite && paddr == `PRS_REMAP_ADDR;
    endsequence

    sequence pa_fall;
        sleep_mode && (($past(p[7:0]) & ~p[7:0]) != 8'h00);
    endsequence

    a_remap_read_back: assert property (remap_read |-> prdata[7:0] == {1'b0, rm_q}) else $error("remap read");
    a_uart_rx_route: assert property (uart_rx == (rm_q[6] ? p[36] : p[19])) else $error("uart rx pin");
    a_irq1_route: assert property (ext_irq1_input == (rm_q[5] ? p[29] : p[24])) else $error("irq1 pin");
    a_irq0_route: assert property (ext_irq0_input == (rm_q[4] ? p[42] : p[41])) else $error("irq0 pin");
    a_stm1_cap_route: assert property (std_timer1_capture_in == (rm_q[3] ? p[7] : p[15])) else $error("stm1 cap");
    a_ptm_clk_route: assert property (periodic_timer_ext_clock == (rm_q[2] ? p[26] : p[19])) else $error("ptm clk");
    a_stm0_clk_route: assert property (std_timer0_ext_clock == (rm_q[1] ? p[36] : p[6])) else $error("stm0 clk");
    a_pull_cut_off: assert property ((port_pull_en & port_analog_sel) == 48'h0000_0000_0000) else $error("pull");
    a_wake_needs_fall: assert property (wake_up |-> pa_fall) else $error("wake");
endmodule // prs_remap_monitor

bind prs_pin_remap_select prs_remap_monitor mon (.*);

/* File: verif/pin_remap_select_test.sv */
`timescale 1ns/10ps
`include "prs_consts.svh"
module pin_remap_select_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, wake_up, irq, adc_on;
    logic [47:0] pin_in, pin_out, pin_oe, pull_en, ana, ev = 48'h0000_0000_0000, ed = 48'hffff_ffff_ffff;
    logic [10:0] pr = 11'h000;
    logic [8:0] rt;
    logic [32:0] q[$];
    logic [32:0] e;
    logic [7:0] v;
    logic [6:0] r;
    int miscompares = 0, num_checks = 0, cycles = 0;

    prs_pin_remap_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pin_in(pin_in),
        .port_pin_out(pin_out), .port_pin_oe(pin_oe), .port_pull_en(pull_en), .port_analog_sel(ana),
        .adc_power_on(adc_on), .sleep_mode(sleep_mode), .wake_up(wake_up), .irq(irq), .uart_tx(pr[0]),
        .uart_tx_en(pr[1]), .uart_rx(rt[0]), .ext_irq0_input(rt[1]), .ext_irq1_input(rt[2]),
        .std_timer0_output(pr[2]), .std_timer0_output_en(pr[3]), .std_timer0_capture_in(rt[3]),
        .std_timer0_ext_clock(rt[4]), .std_timer1_output(pr[4]), .std_timer1_output_en(pr[5]),
        .std_timer1_capture_in(rt[5]), .std_timer1_ext_clock(rt[6]), .periodic_timer_output(pr[6]),
        .periodic_timer_output_en(pr[7]), .periodic_timer_capture_in(rt[7]), .periodic_timer_ext_clock(rt[8]),
        .lcd_common_line3(pr[8]), .lcd_common_line2(pr[9]), .lcd_common_en(pr[10]));
    prs_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en), .ext_val(ev),
        .ext_drv(ed), .level(pin_in));

    always #10 pclk = ~pclk;

    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(x);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0_0000_0000);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        apb(1'b0, a, 32'h0000_0000, x);
    endtask

    // Read results, oldest note first
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = q.pop_front();
            cmp({15'h0000, pslverr, prdata}, {15'h0000, e});
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h87b4a101));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        cmp(pin_oe, 48'h0000_0000_0000);
        cmp(48'(adc_on), 48'h0000_0000_0000);
        cmp(ana, 48'h0000_0000_00ff);
        rd(12'h120, 33'h0_0000_00ff);
        rd(12'h124, 33'h0_0000_00ff);
        for (int i = 0; i < 5; i++) begin
            v = (i == 4) ? 8'h80 : 8'($urandom) | 8'h80;
            r = v[6:0];
            @(posedge pclk);
            ev <= 48'({$urandom, $urandom});
            wr(`PRS_REMAP_ADDR, {24'h00_0000, v});
            cmp(48'(rt[2:0]), 48'({r[5] ? ev[29] : ev[24], r[4] ? ev[42] : ev[41], r[6] ? ev[36] : ev[19]}));
            cmp(48'(rt[8:3]), 48'({r[2] ? ev[26] : ev[19], r[2] ? ev[28] : ev[14], r[3] ? ev[37] : ev[39],
                r[3] ? ev[7] : ev[15], r[1] ? ev[36] : ev[6], r[1] ? ev[30] : ev[5]}));
            rd(`PRS_REMAP_ADDR, {26'h000_0000, r});
        end
        wr(12'h124, 32'h0000_00ef);
        cmp(48'({pin_oe[12], pin_out[12]}), 48'h0000_0000_0003);
        @(posedge pclk);
        pr <= 11'h402;
        #1;
        cmp(48'({pin_out[12], pin_oe[23], pin_out[23]}), 48'h0000_0000_0002);
        pr <= 11'h702;
        wr(`PRS_REMAP_ADDR, 32'h0000_0001);
        cmp(48'({pin_oe[23], pin_oe[26], pin_out[26], pin_oe[31], pin_out[31]}), 48'h0000_0000_000f);
        @(posedge pclk);
        pr <= 11'h000;
        v = 8'($urandom);
        ev[31:24] <= v;
        wr(`PRS_BITOP_ADDR, 32'h0000_0033);
        rd(12'h160, {25'h000_0000, v & 8'hf7});
        wr(12'h108, 32'h0000_00ff);
        cmp(48'(pull_en[7:0]), 48'h0000_0000_0000);
        wr(12'h10c, 32'h0000_0000);
        cmp(48'(pull_en[7:0]), 48'h0000_0000_00ff);
        wr(`PRS_WAKE_EN_ADDR, 32'h0000_0004);
        wr(`PRS_MASK_ADDR, 32'h0000_0004);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        ev[7:0] <= 8'hff;
        @(posedge pclk);
        ev[7:0] <= 8'hfb;
        #1;
        cmp(48'({wake_up, irq}), 48'h0000_0000_0002);
        @(posedge pclk);
        #1;
        cmp(48'({wake_up, irq}), 48'h0000_0000_0001);
        rd(`PRS_STATUS_ADDR, 33'h0_0000_0004);
        cmp(48'(irq), 48'h0000_0000_0000);
        wr(`PRS_MASK_ADDR, 32'h0000_0000);
        @(posedge pclk);
        ev[7:0] <= 8'hff;
        @(posedge pclk);
        ev[7:0] <= 8'hfb;
        repeat (2) @(posedge pclk);
        #1;
        cmp(48'(irq), 48'h0000_0000_0000);
        rd(`PRS_STATUS_ADDR, 33'h0_0000_0004);
        rd(12'h0fc, 33'h1_0000_0000);
        test_done();
    end
endmodule // pin_remap_select_test
